// ---- src/input_gearbox_deserializer.v ----
// input gearbox: sampled link, three-stage deserializer, word buffer
`include "gearbox_consts.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module word_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_reg;
    reg [AW-1:0]    rdPtr_reg;
    reg [AW:0]      count_reg;
    wire            doWrite;
    wire            doRead;

    assign inReady  = (count_reg != DEPTH[AW:0]);
    assign outValid = (count_reg != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_reg];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    always @(posedge sys_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
            end
            if (doRead) begin
                rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
            end
            if (doWrite && !doRead) begin
                count_reg <= count_reg + 1'b1;
            end else if (doRead && !doWrite) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module input_gearbox_deserializer #(
    parameter FIFO_DEPTH = `FIFO_DEPTH,
    parameter FIFO_AW    = 4
) (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       fast_edge_clock,
    input  wire       delayedDataA,
    input  wire       delayedDataC,
    input  wire [1:0] gearMode,
    input  wire       word_slip_strobe,
    input  wire       align_phase_pick,
    output reg  [7:0] q_reg,
    output reg        qValid_reg,
    input  wire       coreReady,
    output wire       wordReady,
    output reg        wordDropped_reg
);
    // three-stage synchronisers for link clock and both data lanes
    reg [2:0] clkSync_reg;
    reg [2:0] aSync_reg;
    reg [2:0] cSync_reg;
    reg       clkStable_reg;
    reg       aStable_reg;
    reg       cStable_reg;
    reg       clkPrev_reg;
    reg [4:0] warm_reg;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            warm_reg      <= 5'h00;
            clkSync_reg   <= 3'h0;
            aSync_reg     <= 3'h0;
            cSync_reg     <= 3'h0;
            clkStable_reg <= 1'b0;
            aStable_reg   <= 1'b0;
            cStable_reg   <= 1'b0;
            clkPrev_reg   <= 1'b0;
        end else begin
            warm_reg    <= {warm_reg[3:0], 1'b1};
            clkSync_reg <= {clkSync_reg[1:0], fast_edge_clock};
            aSync_reg   <= {aSync_reg[1:0], delayedDataA};
            cSync_reg   <= {cSync_reg[1:0], delayedDataC};
            if (clkSync_reg[1] == clkSync_reg[2]) begin
                clkStable_reg <= clkSync_reg[2];
            end
            if (aSync_reg[1] == aSync_reg[2]) begin
                aStable_reg <= aSync_reg[2];
            end
            if (cSync_reg[1] == cSync_reg[2]) begin
                cStable_reg <= cSync_reg[2];
            end
            clkPrev_reg <= clkStable_reg;
        end
    end

    // either edge of the link clock is a bit time
    // link clock may idle high: no edge until the chain has filled after reset
    wire bitEdge = warm_reg[4] && (clkStable_reg ^ clkPrev_reg);

    ////////////////////////////////////////////////////////////////////////////
    // stage one: double-edge capture and bit history
    reg [8:0] histA_reg;
    reg [4:0] histC_reg;
    reg       bitValid_reg;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            histA_reg    <= 9'h000;
            histC_reg    <= 5'h00;
            bitValid_reg <= 1'b0;
        end else begin
            bitValid_reg <= bitEdge;
            if (bitEdge) begin
                histA_reg <= {histA_reg[7:0], aStable_reg};
                histC_reg <= {histC_reg[3:0], cStable_reg};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // word boundary counter with slip
    reg  [2:0] bitCount_reg;
    reg        slipPending_reg;
    reg  [2:0] lastBit;
    wire       update;
    wire       slipTaken;

    always @* begin
        case (gearMode)
            `MODE_SEVEN:      lastBit = `LAST_BIT_SEVEN;
            `MODE_FOUR_SPLIT: lastBit = `LAST_BIT_FOUR;
            default:          lastBit = `LAST_BIT_EIGHT;
        endcase
    end

    // a slipped bit is not counted, so the boundary moves one bit later
    assign slipTaken = bitValid_reg && slipPending_reg;
    assign update    = bitValid_reg && !slipPending_reg && (bitCount_reg == lastBit);

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bitCount_reg    <= `COUNT_RESET;
            slipPending_reg <= 1'b0;
        end else begin
            // a new request in the consuming cycle wins over the clear
            if (word_slip_strobe) begin
                slipPending_reg <= 1'b1;
            end else if (slipTaken) begin
                slipPending_reg <= 1'b0;
            end
            if (bitValid_reg && !slipPending_reg) begin
                bitCount_reg <= (bitCount_reg == lastBit) ? `COUNT_RESET : bitCount_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stage two: aligned word on update, window chosen by phase pick
    reg  [7:0] aligned_reg;
    reg        alignedValid_reg;
    wire [7:0] winA = align_phase_pick ? histA_reg[8:1] : histA_reg[7:0];
    wire [3:0] winC = align_phase_pick ? histC_reg[4:1] : histC_reg[3:0];
    reg  [7:0] wordNext;

    always @* begin
        case (gearMode)
            `MODE_SEVEN:      wordNext = {1'b0, winA[6:0]};
            `MODE_FOUR_SPLIT: wordNext = {winA[3:0], winC};
            default:          wordNext = winA;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aligned_reg      <= `WORD_RESET;
            alignedValid_reg <= 1'b0;
        end else begin
            alignedValid_reg <= update;
            if (update) begin
                aligned_reg <= wordNext;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // buffer, then stage three towards the core
    wire       fifoOutValid;
    wire       fifoOutReady;
    wire [7:0] fifoOutData;

    word_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) buffer (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .inValid  (alignedValid_reg),
        .inReady  (wordReady),
        .inData   (aligned_reg),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    assign fifoOutReady = !qValid_reg || coreReady;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_reg           <= `WORD_RESET;
            qValid_reg      <= 1'b0;
            wordDropped_reg <= 1'b0;
        end else begin
            // the link cannot be stalled; a full buffer loses the word
            if (alignedValid_reg && !wordReady) begin
                wordDropped_reg <= 1'b1;
            end
            if (fifoOutReady) begin
                qValid_reg <= fifoOutValid;
                if (fifoOutValid) begin
                    q_reg <= fifoOutData;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ---- src/gearbox_consts.vh ----
// constants for the input gearbox deserializer
`ifndef GEARBOX_CONSTS_VH
`define GEARBOX_CONSTS_VH

// gear mode encodings
`define MODE_SEVEN      2'h0
`define MODE_EIGHT      2'h1
`define MODE_FOUR_SPLIT 2'h2

// last bit index of a word per mode
`define LAST_BIT_SEVEN  3'h6
`define LAST_BIT_EIGHT  3'h7
`define LAST_BIT_FOUR   3'h3

// lane positions on the parallel bus
`define LANE_A_LSB      4
`define LANE_C_LSB      0

// reset values
`define WORD_RESET      8'h00
`define COUNT_RESET     3'h0

// output buffer depth
`define FIFO_DEPTH      16

`endif

// ---- verification/serial_source.sv ----
// serial link source model: bit clock and two data lanes
`default_nettype none
module serial_source (
    output logic linkClk,
    output logic dataA,
    output logic dataC
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        linkClk = 1'b0;
        dataA = 1'b0;
        dataC = 1'b1;
    end
    // data moves midway between link edges: margin on both sides
    task automatic send(input logic [8:0] a, input logic [8:0] c, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            dataA = a[i];
            dataC = c[i];
            #200 linkClk = ~linkClk;
            #200;
        end
        // released lanes flip so stale bits never look valid
        dataA = ~dataA;
        dataC = ~dataC;
    endtask
endmodule
`default_nettype wire

// ---- verification/gearbox_asserts.sv ----
// port checker for the input gearbox
`default_nettype none
module gearbox_asserts #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       fast_edge_clock,
    input wire logic       word_slip_strobe,
    input wire logic [7:0] q_reg,
    input wire logic       qValid_reg,
    input wire logic       coreReady,
    input wire logic       wordReady,
    input wire logic       wordDropped_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] quietCnt;
    logic       lastClk;
    // cycles since the link clock last moved, saturating
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            quietCnt <= 4'h0;
            lastClk <= 1'b0;
        end else begin
            lastClk <= fast_edge_clock;
            if (lastClk != fast_edge_clock) quietCnt <= 4'h0;
            else if (quietCnt != 4'hf) quietCnt <= quietCnt + 4'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence take_s;
        qValid_reg && coreReady;
    endsequence
    sequence wait_s;
        qValid_reg && !coreReady;
    endsequence
    hold_word_a: assert property (wait_s |=> qValid_reg && $stable(q_reg))
        else $error("word changed before taken");
    take_ready_a: assert property (take_s and quietCnt > 4'hc |=> wordReady)
        else $error("buffer full after take");
    full_hold_a: assert property (!wordReady |-> qValid_reg)
        else $error("full buffer but no word out");
    drop_sticky_a: assert property (wordDropped_reg |=> wordDropped_reg)
        else $error("drop flag cleared");
    drop_cause_a: assert property ($rose(wordDropped_reg) |-> !$past(wordReady))
        else $error("drop without full buffer");
    reset_out_a: assert property ($fell(rst) |-> q_reg == 8'h00 && !qValid_reg && !wordDropped_reg)
        else $error("outputs not clear after reset");
    link_cause_a: assert property ($rose(qValid_reg) |-> quietCnt < 4'hc)
        else $error("word without link edges");
    slip_quiet_a: assert property (word_slip_strobe && !qValid_reg && quietCnt > 4'hc |=> !qValid_reg)
        else $error("slip alone made a word");
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// testbench for the input gearbox deserializer
`include "gearbox_consts.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] gearMode = `MODE_EIGHT;
    logic       word_slip_strobe = 1'b0;
    logic       align_phase_pick = 1'b0;
    logic       coreReady = 1'b0;
    wire        linkClk, dataA, dataC, wordReady;
    wire  [7:0] q_reg;
    wire        qValid_reg, wordDropped_reg;
    int         n_errors = 0;
    int         n_tests = 0;
    always #50 sys_clk = ~sys_clk;
    serial_source src_u (.linkClk(linkClk), .dataA(dataA), .dataC(dataC));
    input_gearbox_deserializer dut_u (.sys_clk(sys_clk), .rst(rst), .fast_edge_clock(linkClk),
        .delayedDataA(dataA), .delayedDataC(dataC), .gearMode(gearMode), .word_slip_strobe(word_slip_strobe),
        .align_phase_pick(align_phase_pick), .q_reg(q_reg), .qValid_reg(qValid_reg), .coreReady(coreReady),
        .wordReady(wordReady), .wordDropped_reg(wordDropped_reg));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic get_word(input logic [7:0] exp);
        int n;
        n = 0;
        while (qValid_reg !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 300) begin
            n_errors++;
            $display("CHECK FAILED %0t: no word within bound", $time);
            print_verdict();
        end else begin
            check(q_reg, exp);
            @(posedge sys_clk) coreReady <= 1'b1;
            @(posedge sys_clk) coreReady <= 1'b0;
            @(negedge sys_clk);
        end
    endtask
    ////////////////////////////////////////
    task automatic modes_test();
        logic [1:0] m[4] = '{`MODE_EIGHT, `MODE_SEVEN, `MODE_FOUR_SPLIT, 2'h3};
        logic [7:0] a[4] = '{8'ha5, 8'hfb, 8'h0c, 8'h3c};
        logic [7:0] c[4] = '{8'h5a, 8'h04, 8'h03, 8'hc3};
        logic [7:0] e[4] = '{8'ha5, 8'h7b, 8'hc3, 8'h3c};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) gearMode <= m[i];
            @(negedge sys_clk);
            src_u.send({1'b0, a[i]}, {1'b0, c[i]}, m[i] == `MODE_SEVEN ? 7 : m[i] == `MODE_FOUR_SPLIT ? 4 : 8);
            get_word(e[i]);
        end
        $display("modes test done");
    endtask
    task automatic slip_test();
        @(posedge sys_clk) gearMode <= `MODE_EIGHT;
        repeat (12) @(posedge sys_clk);
        word_slip_strobe <= 1'b1;
        @(posedge sys_clk) word_slip_strobe <= 1'b0;
        @(negedge sys_clk);
        src_u.send(9'h0a5, 9'h1ff, 9);
        get_word(8'ha5);
        @(posedge sys_clk) align_phase_pick <= 1'b1;
        @(negedge sys_clk);
        src_u.send(9'h000, 9'h1ff, 8);
        get_word(8'h80);
        @(posedge sys_clk) align_phase_pick <= 1'b0;
        $display("slip and phase test done");
    endtask
    // core stalls: 16 buffered plus one held at the output, then one lost
    task automatic fifo_test();
        @(negedge sys_clk);
        for (int i = 0; i < 18; i++) src_u.send({1'b0, 8'(i)}, 9'h1ff, 8);
        repeat (12) @(negedge sys_clk);
        check({6'h00, wordDropped_reg, wordReady}, 8'h02);
        for (int k = 0; k < 17; k++) get_word(8'(k));
        check({7'h00, qValid_reg}, 8'h00);
        $display("buffer test done");
    endtask
    task automatic reset_test();
        src_u.send(9'h0ff, 9'h1ff, 5);
        @(posedge sys_clk) rst <= 1'b1;
        @(negedge sys_clk);
        check(q_reg, 8'h00);
        check({5'h00, qValid_reg, wordDropped_reg, wordReady}, 8'h01);
        @(posedge sys_clk) rst <= 1'b0;
        @(negedge sys_clk);
        src_u.send(9'h03c, 9'h1ff, 8);
        get_word(8'h3c);
        $display("reset test done");
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        modes_test();
        slip_test();
        fifo_test();
        reset_test();
        print_verdict();
    end
endmodule
bind input_gearbox_deserializer gearbox_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) chk_u (
    .sys_clk(sys_clk), .rst(rst), .fast_edge_clock(fast_edge_clock), .word_slip_strobe(word_slip_strobe),
    .q_reg(q_reg), .qValid_reg(qValid_reg), .coreReady(coreReady), .wordReady(wordReady),
    .wordDropped_reg(wordDropped_reg));
`default_nettype wire
